// ---- icw_pkg.sv ----
// shared constants for the i2c configuration write link: both ends, and
// the register map that the controller end shows to software.
// assumes a 100 MHz system clock on the controller end.
package icw_pkg;
    // ------------------------------------------------------------
    // slave address
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED = 4'hD;       // address bits 6..3
    localparam logic [6:0] ADDR_DEFAULT = 7'h68;    // controller reset target
    // ------------------------------------------------------------
    // packet layout: byte 0 address, 1..4 command, 5..8 data
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_CMD0 = 4'h1;
    localparam logic [3:0] IDX_DATA0 = 4'h5;
    localparam logic [3:0] IDX_LAST = 4'h8;
    localparam logic [3:0] IDX_DONE = 4'h9;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    // command word: byte 0 in [31:24] down to byte 3 in [7:0]
    localparam int OP_LSB = 24;
    localparam int PORT_HI_LSB = 16;
    localparam int PORT_LO_BIT = 15;
    localparam int BE_LSB = 10;
    localparam int ADDR_HI_LSB = 8;
    localparam int ADDR_LO_LSB = 0;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [4:0] PORT_MAX = 5'h05;
    localparam logic [1:0] DWORD_ALIGN = 2'h0;
    // ------------------------------------------------------------
    // controller register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TARGET = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_GO = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_DONE = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;           // 100 kbit/s
    localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_SYS_NS);
endpackage

// ---- icw_link_if.sv ----
// the two-wire link between controller and device end.
// assumes both wires are open drain with pull-ups: a released wire reads 1.
interface icw_link_if;
    logic hostSclOut;
    logic hostSclOen;
    logic hostSdaOut;
    logic hostSdaOen;
    logic devSdaOut;
    logic devSdaOen;
    logic scl;
    logic sda;
    // wired-and: enable low means driving
    assign scl = hostSclOen | hostSclOut;
    assign sda = (hostSdaOen | hostSdaOut) & (devSdaOen | devSdaOut);
    modport dev(input scl, input sda, output devSdaOut, output devSdaOen);
    modport host(input scl, input sda, output hostSclOut, output hostSclOen,
        output hostSdaOut, output hostSdaOen);
endinterface

// ---- icw_device.sv ----
// device end: i2c write slave that turns packets into config writes.
// assumes clkLink is the device core clock, several times faster than scl,
// and that the register file behind it applies cfgByteEn itself.
//
// Function
// R1 - address bits 2..0 from straps, rest 1011; the code uses 1101 (ADDR_FIXED = 4'hD)
// R2 - software address replaces strap address
// R3 - works independent of upstream link
// R4 - master frames with start, ack, stop
// R5 - always four data bytes per write
// R6 - first data byte is bits 31..24
// R7 - nack every data byte beyond fourth
// R8 - after fourth byte, stop or repeated start
// R9 - invalid command leaves register unchanged
// R10 - opcode 011b in byte 0 bits 2..0
// R11 - port select from byte1[3:0], byte2[7]
// R12 - port selector 0..5 picks switch port
// R13 - byte 2 bits 5..2 are byte enables
// R14 - address 11..2 from commands, 1..0 zero
// R15 - ack address only on own address
// R16 - commit after fourth data byte acked
module icw_device #(
    parameter int NUM_PORTS = 6
) (
    // link clock and reset
    input wire logic clkLink,
    input wire logic rst,
    // the bus
    icw_link_if.dev link,
    // address selection
    input wire logic [2:0] strapPins,
    input wire logic swAddrValid,
    input wire logic [6:0] swAddr,
    // configuration write toward the switch ports
    output logic cfgWrite,
    output logic [NUM_PORTS-1:0] cfgPortSel,
    output logic [4:0] cfgPortNum,
    output logic [11:0] cfgAddr,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgData,
    output logic busActive
);
    // ------------------------------------------------------------
    // pin synchronisers and glitch filter
    // ------------------------------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] filt_q;
    logic [1:0] prev_q;
    // {scl, sda}: a level counts once the second and third stage agree
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            sync3_q <= 2'h3;
            filt_q <= 2'h3;
            prev_q <= 2'h3;
        end else begin
            sync1_q <= {link.scl, link.sda};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q[1] == sync3_q[1]) filt_q[1] <= sync3_q[1];
            if (sync2_q[0] == sync3_q[0]) filt_q[0] <= sync3_q[0];
            prev_q <= filt_q;
        end
    end

    // bus events; start and stop only happen while scl stays high [R4]
    wire sclRise = filt_q[1] & ~prev_q[1];
    wire sclFall = ~filt_q[1] & prev_q[1];
    wire sclHeld = filt_q[1] & prev_q[1];
    wire startSeen = sclHeld & prev_q[0] & ~filt_q[0];
    wire stopSeen = sclHeld & ~prev_q[0] & filt_q[0];

    // ------------------------------------------------------------
    // slave address
    // ------------------------------------------------------------
    logic [2:0] strap_q;
    logic strapTaken_q;
    // straps are caught once, on the first edge after reset release [R1]
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            strap_q <= 3'h0;
            strapTaken_q <= 1'b0;
        end else if (!strapTaken_q) begin
            strap_q <= strapPins;
            strapTaken_q <= 1'b1;
        end
    end
    wire [6:0] strapAddr = {icw_pkg::ADDR_FIXED, strap_q};          // [R1]
    wire [6:0] ownAddr = swAddrValid ? swAddr : strapAddr;          // [R2]

    // ------------------------------------------------------------
    // byte receiver
    // ------------------------------------------------------------
    logic active_q;
    logic inAck_q;
    logic acked_q;
    logic sdaOen_q;
    logic [3:0] bitCnt_q;
    logic [3:0] idx_q;
    logic [7:0] shift_q;
    logic [31:0] cmd_q;
    logic [31:0] data_q;

    // the address byte is acked for a write to our own address only [R15]
    wire addrHit = (shift_q[7:1] == ownAddr) && !shift_q[0];
    // bytes past the fourth data byte get a nack [R7]
    wire wantAck = (idx_q == icw_pkg::IDX_ADDR) ? addrHit : (idx_q < icw_pkg::IDX_DONE);
    wire byteEnd = active_q & sclFall & ~inAck_q & (bitCnt_q == icw_pkg::BITS_BYTE);
    wire ackEnd = active_q & sclFall & inAck_q;
    wire isCmd = (idx_q >= icw_pkg::IDX_CMD0) && (idx_q < icw_pkg::IDX_DATA0);
    wire isData = (idx_q >= icw_pkg::IDX_DATA0) && (idx_q <= icw_pkg::IDX_LAST);

    // framing: a repeated start restarts the packet from the address [R8]
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
            inAck_q <= 1'b0;
            acked_q <= 1'b0;
            sdaOen_q <= 1'b1;
            bitCnt_q <= 4'h0;
            idx_q <= 4'h0;
        end else if (startSeen) begin
            active_q <= 1'b1;
            inAck_q <= 1'b0;
            sdaOen_q <= 1'b1;
            bitCnt_q <= 4'h0;
            idx_q <= icw_pkg::IDX_ADDR;
        end else if (stopSeen) begin
            active_q <= 1'b0;
            inAck_q <= 1'b0;
            sdaOen_q <= 1'b1;
        end else if (byteEnd) begin
            inAck_q <= 1'b1;
            acked_q <= wantAck;
            sdaOen_q <= ~wantAck;                   // pull low to ack
            if (idx_q < icw_pkg::IDX_DONE) idx_q <= idx_q + 4'h1;
        end else if (ackEnd) begin
            inAck_q <= 1'b0;
            sdaOen_q <= 1'b1;                       // release for next byte
            bitCnt_q <= 4'h0;
            if (!acked_q) active_q <= 1'b0;         // ignore rest until start
        end else if (active_q && sclRise && !inAck_q && bitCnt_q < icw_pkg::BITS_BYTE) begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // shifter and byte store, msb first; command and data fill msb first [R6]
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            shift_q <= 8'h00;
            cmd_q <= 32'h0000_0000;
            data_q <= 32'h0000_0000;
        end else if (active_q && sclRise && !inAck_q && bitCnt_q < icw_pkg::BITS_BYTE) begin
            shift_q <= {shift_q[6:0], filt_q[0]};
        end else if (byteEnd && isCmd) begin
            cmd_q <= {cmd_q[23:0], shift_q};
        end else if (byteEnd && isData) begin
            data_q <= {data_q[23:0], shift_q};      // [R6]
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire [2:0] opcode = cmd_q[icw_pkg::OP_LSB +: 3];                               // [R10]
    wire [4:0] portNum = {cmd_q[icw_pkg::PORT_HI_LSB +: 4], cmd_q[icw_pkg::PORT_LO_BIT]}; // [R11]
    wire [3:0] byteEn = cmd_q[icw_pkg::BE_LSB +: 4];                               // [R13]
    wire [11:0] regAddr = {cmd_q[icw_pkg::ADDR_HI_LSB +: 2],
        cmd_q[icw_pkg::ADDR_LO_LSB +: 8], icw_pkg::DWORD_ALIGN};                   // [R14]
    // unknown opcode or port outside 0..5 is dropped [R9]
    wire cmdValid = (opcode == icw_pkg::OP_WRITE) && (portNum <= icw_pkg::PORT_MAX);
    // commit only once all four data bytes are in and acked [R5] [R16]
    wire commit = ackEnd && acked_q && (idx_q == icw_pkg::IDX_DONE) && cmdValid;

    // one-hot port select, one line per port [R12]
    wire [NUM_PORTS-1:0] portHot;
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : gPort
            assign portHot[gp] = (portNum == 5'(gp));
        end
    endgenerate

    // ------------------------------------------------------------
    // write port toward the register file
    // ------------------------------------------------------------
    logic cfgWrite_q;
    logic [NUM_PORTS-1:0] portSel_q;
    logic [4:0] portNum_q;
    logic [11:0] addr_q;
    logic [3:0] be_q;
    logic [31:0] wdata_q;
    // fields hold until the next commit; the strobe lasts one cycle
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            cfgWrite_q <= 1'b0;
            portSel_q <= '0;
            portNum_q <= 5'h00;
            addr_q <= 12'h000;
            be_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
        end else begin
            cfgWrite_q <= commit;                   // [R16]
            if (commit) begin
                portSel_q <= portHot;               // [R12]
                portNum_q <= portNum;
                addr_q <= regAddr;                  // [R14]
                be_q <= byteEn;                     // [R13]
                wdata_q <= data_q;                  // [R6]
            end
        end
    end

    // sda is open drain: output stays low, the enable does the work
    logic sdaOut_q;
    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) sdaOut_q <= 1'b0;
        else sdaOut_q <= 1'b0;
    end

    // nothing here looks at the upstream link, so access always works [R3]
    assign link.devSdaOut = sdaOut_q;
    assign link.devSdaOen = sdaOen_q;
    assign cfgWrite = cfgWrite_q;
    assign cfgPortSel = portSel_q;
    assign cfgPortNum = portNum_q;
    assign cfgAddr = addr_q;
    assign cfgByteEn = be_q;
    assign cfgData = wdata_q;
    assign busActive = active_q;
endmodule

// ---- icw_host.sv ----
// controller end: wishbone-programmed i2c master that sends one nine-byte
// configuration write packet per go command.
// assumes it is the only master on the bus and that nobody stretches scl.
module icw_host #(
    parameter int QTR = icw_pkg::QTR_CYCLES
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // the bus
    icw_link_if.host link
);
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} icw_hstate_type;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdat_q;
    logic [6:0] target_q;
    logic [31:0] cmd_q;
    logic [31:0] data_q;
    logic busy_q;
    logic nack_q;
    logic done_q;
    wire take = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr = take & wb_we_i;
    wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // byte-lane merge for the command and data registers
    wire [31:0] cmdNext = (cmd_q & ~selMask) | (wb_dat_i & selMask);
    wire [31:0] dataNext = (data_q & ~selMask) | (wb_dat_i & selMask);
    // a go while busy is ignored: a second go never restarts the packet in flight
    wire go = wr && wb_adr_i == icw_pkg::REG_CTRL && wb_sel_i[0]
        && wb_dat_i[icw_pkg::CTRL_GO] && !busy_q;
    wire [31:0] status = {29'h0, done_q, nack_q, busy_q};
    wire [31:0] rdData = (wb_adr_i == icw_pkg::REG_TARGET) ? {25'h0, target_q} :
        (wb_adr_i == icw_pkg::REG_CMD) ? cmd_q :
        (wb_adr_i == icw_pkg::REG_DATA) ? data_q :
        (wb_adr_i == icw_pkg::REG_STATUS) ? status : 32'h0000_0000;

    // answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            target_q <= icw_pkg::ADDR_DEFAULT;
            cmd_q <= 32'h0000_0000;
            data_q <= 32'h0000_0000;
        end else begin
            ack_q <= take;
            if (take) rdat_q <= rdData;
            if (wr && wb_adr_i == icw_pkg::REG_TARGET && wb_sel_i[0]) target_q <= wb_dat_i[6:0];
            if (wr && wb_adr_i == icw_pkg::REG_CMD) cmd_q <= cmdNext;
            if (wr && wb_adr_i == icw_pkg::REG_DATA) data_q <= dataNext;
        end
    end

    // ------------------------------------------------------------
    // sda sense and quarter-bit tick
    // ------------------------------------------------------------
    logic [2:0] sdaSync_q;
    logic sdaS_q;
    logic [15:0] div_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sdaSync_q <= 3'h7;
            sdaS_q <= 1'b1;
        end else begin
            sdaSync_q <= {sdaSync_q[1:0], link.sda};
            if (sdaSync_q[1] == sdaSync_q[2]) sdaS_q <= sdaSync_q[2];
        end
    end
    wire tick = (div_q == 16'h0000);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) div_q <= 16'h0000;
        else if (go || tick) div_q <= 16'(QTR - 1);
        else div_q <= div_q - 16'h0001;
    end

    // ------------------------------------------------------------
    // packet engine: four quarters per bit, scl made by the divider
    // ------------------------------------------------------------
    icw_hstate_type state_q;
    logic [1:0] phase_q;
    logic [3:0] bitNo_q;
    logic [3:0] byteNo_q;
    logic sclOen_q;
    logic sdaOen_q;
    // byte 0 is address plus write bit, then command then data, msb first
    wire [7:0] txByte = (byteNo_q == icw_pkg::IDX_ADDR) ? {target_q, 1'b0} :
        (byteNo_q < icw_pkg::IDX_DATA0) ? cmd_q[8 * (5 - byteNo_q) - 1 -: 8] :
        data_q[8 * (8 - byteNo_q) + 7 -: 8];
    wire isAckBit = (bitNo_q == icw_pkg::BITS_BYTE);
    wire txBit = isAckBit ? 1'b1 : txByte[3'(7 - bitNo_q)];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= HS_IDLE;
            phase_q <= 2'h0;
            bitNo_q <= 4'h0;
            byteNo_q <= 4'h0;
            sclOen_q <= 1'b1;
            sdaOen_q <= 1'b1;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else if (go) begin
            state_q <= HS_START;
            phase_q <= 2'h0;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else if (tick && state_q != HS_IDLE) begin
            phase_q <= phase_q + 2'h1;
            unique case (state_q)
                HS_START: begin
                    if (phase_q == 2'h1) sdaOen_q <= 1'b0;      // start [R4]
                    if (phase_q == 2'h2) sclOen_q <= 1'b0;
                    if (phase_q == 2'h3) begin
                        state_q <= HS_BIT;
                        bitNo_q <= 4'h0;
                        byteNo_q <= icw_pkg::IDX_ADDR;
                    end
                end
                HS_BIT: begin
                    if (phase_q == 2'h0) sdaOen_q <= txBit;
                    if (phase_q == 2'h1) sclOen_q <= 1'b1;
                    if (phase_q == 2'h2 && isAckBit && sdaS_q) nack_q <= 1'b1;
                    if (phase_q == 2'h3) begin
                        sclOen_q <= 1'b0;
                        bitNo_q <= isAckBit ? 4'h0 : bitNo_q + 4'h1;
                        if (isAckBit && (nack_q || byteNo_q == icw_pkg::IDX_LAST)) begin
                            state_q <= HS_STOP;  // four data bytes then stop [R5] [R8]
                        end else if (isAckBit) begin
                            byteNo_q <= byteNo_q + 4'h1;
                        end
                    end
                end
                HS_STOP: begin
                    if (phase_q == 2'h0) sdaOen_q <= 1'b0;
                    if (phase_q == 2'h1) sclOen_q <= 1'b1;
                    if (phase_q == 2'h2) sdaOen_q <= 1'b1;      // stop [R4]
                    if (phase_q == 2'h3) begin
                        state_q <= HS_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // open drain: outputs stay low, enables carry the level
    logic zero_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) zero_q <= 1'b0;
        else zero_q <= 1'b0;
    end
    assign link.hostSclOut = zero_q;
    assign link.hostSdaOut = zero_q;
    assign link.hostSclOen = sclOen_q;
    assign link.hostSdaOen = sdaOen_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule

// ---- icw_link_asserts.sv ----
// assertions on the i2c configuration write link and the device commit.
// assumes plain copies of the link wires and device outputs, two clocks.
module icw_link_asserts #(
    parameter int NUM_PORTS = 6
) (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic clkLink,
    input wire logic rst,
    // link wires
    input wire logic hostSclOut,
    input wire logic hostSdaOut,
    input wire logic devSdaOut,
    input wire logic devSdaOen,
    input wire logic scl,
    // device commit
    input wire logic cfgWrite,
    input wire logic [NUM_PORTS-1:0] cfgPortSel,
    input wire logic [4:0] cfgPortNum,
    input wire logic [11:0] cfgAddr,
    input wire logic [31:0] cfgData
);
    // ------------------------
    // wire discipline
    // ------------------------
    // a high drive on an open-drain wire would fight the pull-ups
    property p_hostOutLow;
        @(posedge clk_sys) disable iff (rst) !hostSclOut && !hostSdaOut;
    endproperty
    a_hostOutLow: assert property (p_hostOutLow)
        else $error("host drives a wire high");
    property p_devOutLow;
        @(posedge clkLink) disable iff (rst) !devSdaOut;
    endproperty
    a_devOutLow: assert property (p_devOutLow)
        else $error("device drives sda high");
    // the device moves sda only while scl is low, or it would read as start or stop
    property p_ackSclLow;
        @(posedge clkLink) disable iff (rst) $changed(devSdaOen) |-> !scl;
    endproperty
    a_ackSclLow: assert property (p_ackSclLow)
        else $error("device moved sda while scl high");
    property p_ackHeld;
        @(posedge clkLink) disable iff (rst) $fell(devSdaOen) |-> !devSdaOen [*8];
    endproperty
    a_ackHeld: assert property (p_ackHeld)
        else $error("acknowledge released too early");
    // ------------------------
    // commit
    // ------------------------
    property p_pulse;
        @(posedge clkLink) disable iff (rst) cfgWrite |=> !cfgWrite;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("commit longer than one cycle");
    property p_portSel;
        @(posedge clkLink) disable iff (rst)
            cfgWrite |=> cfgPortNum <= 5'h05 && cfgPortSel == (NUM_PORTS'(1) << cfgPortNum);
    endproperty
    a_portSel: assert property (p_portSel)
        else $error("port select does not match port number");
    property p_align;
        @(posedge clkLink) disable iff (rst) cfgWrite |=> cfgAddr[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align)
        else $error("commit address not dword aligned");
    // data may only move together with a commit
    property p_fieldsHeld;
        @(posedge clkLink) disable iff (rst) $changed(cfgData) |-> cfgWrite || $past(cfgWrite);
    endproperty
    a_fieldsHeld: assert property (p_fieldsHeld)
        else $error("commit data changed without a commit");
    c_commit: cover property (@(posedge clkLink) disable iff (rst) cfgWrite);
    c_ack: cover property (@(posedge clkLink) disable iff (rst) $fell(devSdaOen));
    c_port5: cover property (@(posedge clkLink) disable iff (rst) cfgWrite ##1 cfgPortNum == 5'h05);
endmodule

// ---- tb.sv ----
// self-checking bench: controller end driven over wishbone, device end
// watched at its commit outputs; assumes both meet in icw_link_if.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------
    // signals and instances
    // ------------------------
    logic clk_sys, clkLink, rst;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, cfgByteEn, be;
    logic [31:0] wb_dat_i, wb_dat_o, cfgData, rd, cmd, dat;
    logic [2:0] strapPins;
    logic swAddrValid, cfgWrite, busActive;
    logic [6:0] swAddr;
    logic [5:0] cfgPortSel;
    logic [4:0] cfgPortNum, pn;
    logic [11:0] cfgAddr;
    int failures = 0;
    int comparisons = 0;
    int writeCnt = 0;
    icw_link_if linkBus();
    // a slow quarter bit keeps every level visible to the device filter
    icw_host #(.QTR(26)) u_icw_host (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(linkBus));
    icw_device #(.NUM_PORTS(6)) u_icw_device (.clkLink, .rst, .link(linkBus), .strapPins,
        .swAddrValid, .swAddr, .cfgWrite, .cfgPortSel, .cfgPortNum, .cfgAddr, .cfgByteEn,
        .cfgData, .busActive);
    icw_link_asserts #(.NUM_PORTS(6)) u_icw_link_asserts (.clk_sys, .clkLink, .rst,
        .hostSclOut(linkBus.hostSclOut), .hostSdaOut(linkBus.hostSdaOut),
        .devSdaOut(linkBus.devSdaOut), .devSdaOen(linkBus.devSdaOen), .scl(linkBus.scl),
        .cfgWrite, .cfgPortSel, .cfgPortNum, .cfgAddr, .cfgData);
    // clocks: link clock offset and slower; rising edges still meet every 160 ns
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        clkLink = 1'h0;
        #3;
        forever #16 clkLink = ~clkLink;
    end
    // count commits seen at the device
    always @(posedge clkLink) begin
        if (cfgWrite === 1'h1) begin
            writeCnt <= writeCnt + 1;
        end
    end
    // ------------------------
    // tasks
    // ------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one classic cycle; request held until ack is seen at an edge
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        // the slave must drop ack in the cycle after it gave it
        @(posedge clk_sys);
        chk({31'h0, wb_ack_o}, 32'h0);
    endtask
    // send cmd and dat to tgt, wait for idle, check nack flag and commits
    task automatic sendPkt(input logic [6:0] tgt, input logic nackExp, input int addExp);
        int w0 = writeCnt;
        wbXfer(1'h1, icw_pkg::REG_TARGET, {25'h0, tgt});
        wbXfer(1'h1, icw_pkg::REG_CMD, cmd);
        wbXfer(1'h1, icw_pkg::REG_DATA, dat);
        wbXfer(1'h1, icw_pkg::REG_CTRL, 32'h1);
        do begin
            wbXfer(1'h0, icw_pkg::REG_STATUS, 32'h0);
        end while (rd[icw_pkg::ST_BUSY] !== 1'h0);
        chk({31'h0, rd[icw_pkg::ST_DONE]}, 32'h1);
        chk({31'h0, busActive}, 32'h0);
        chk({31'h0, rd[icw_pkg::ST_NACK]}, {31'h0, nackExp});
        chk(32'(writeCnt - w0), 32'(addExp));
    endtask
    // ------------------------
    // tests
    // ------------------------
    initial begin
        rst = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        strapPins = 3'h5;
        swAddrValid = 1'h0;
        swAddr = 7'h22;
        // the reset is asynchronous, so four system cycles are enough
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (6) @(posedge clkLink);
        wbXfer(1'h0, icw_pkg::REG_TARGET, 32'h0);
        chk(rd, 32'h68);
        wbXfer(1'h0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        // a write to every port, each with its own enables, address and data
        for (int i = 0; i < 6; i++) begin
            pn = 5'(i);
            be = 4'h5 ^ 4'(i);
            cmd = {8'h03, 4'h0, pn[4:1], pn[0], 1'h0, be, 2'h1, 8'h40 + 8'(i)};
            dat = 32'h12345678 + 32'(i) * 32'h01010101;
            sendPkt({4'hD, strapPins}, 1'h0, 1);
            chk({27'h0, cfgPortNum}, 32'(i));
            chk({26'h0, cfgPortSel}, 32'h1 << i);
            chk({20'h0, cfgAddr}, {20'h0, 2'h1, 8'h40 + 8'(i), 2'h0});
            chk({28'h0, cfgByteEn}, {28'h0, be});
            chk(cfgData, dat);
        end
        sendPkt(7'h68, 1'h1, 0);
        // once set, the software address is the only one answered
        @(posedge clkLink);
        swAddrValid <= 1'h1;
        sendPkt({4'hD, strapPins}, 1'h1, 0);
        // new data, so that a wrong commit would show at the outputs
        dat = 32'hA5A5_5A5A;
        cmd[26:24] = 3'h4;
        sendPkt(7'h22, 1'h0, 0);
        cmd = {8'h03, 8'h03, 8'h3C, 8'h3E};
        sendPkt(7'h22, 1'h0, 0);
        chk(cfgData, 32'h1739_5B7D);
        stop_test();
    end
    // watchdog sized for eight full packets plus margin
    initial begin
        repeat (95000) @(posedge clk_sys);
        failures++;
        $display("Error at %0t: run did not finish", $time);
        stop_test();
    end
endmodule
